// *** hdl/xbar_ctrl.sv ***
`timescale 1ns/1ps
`include "xbar_consts.svh"

module xbar_ctrl
#(
    // 0: 3x2, 1: 3x4, 2: 4x3
    parameter int VARIANT     = 1,
    parameter int TIMEOUT_CYC = `XBAR_IDLE_TIMEOUT_CYC
)
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // three-level pins
    input  wire logic [1:0] route_pin_0,
    input  wire logic [1:0] route_pin_1,
    input  wire logic [1:0] route_pin_2,
    input  wire logic [1:0] route_pin_3,
    input  wire logic [1:0] route_pin_4,
    input  wire logic [1:0] route_pin_5,
    input  wire logic [1:0] powerdown_n_pin,
    // two-level pins
    input  wire logic       iface_select,
    input  wire logic       lin_rx_line,
    // serial register engine
    input  wire logic       ser_wr_valid,
    input  wire logic [7:0] ser_wr_addr,
    input  wire logic [7:0] ser_wr_data,
    // lin frame engine
    input  wire logic       lin_frame_valid,
    input  wire logic       lin_cksum_ok,
    input  wire logic [7:0] lin_frame_d1,
    input  wire logic [7:0] lin_frame_d2,
    input  wire logic       lin_sleep_cmd,
    input  wire logic       lin_tx_data,
    // switch control
    output logic [2:0]      out_port_0_sel,
    output logic [2:0]      out_port_1_sel,
    output logic [2:0]      out_port_2_sel,
    output logic [2:0]      out_port_3_sel,
    output logic [3:0]      out_preemph,
    // status
    output logic            lin_mode,
    output logic            serial_active,
    output logic            power_down,
    output logic            route_override,
    output logic [7:0]      route_a_q,
    output logic [7:0]      route_b_q,
    // transceiver
    output logic            xcvr_wake_ctl,
    output logic            lin_tx_line,
    output logic            lin_tx_oe
);

    generate
        if (VARIANT < 0 || VARIANT > 2)
        begin : g_bad
            $error("xbar_ctrl: VARIANT must be 0, 1 or 2");
        end
    endgenerate

    localparam logic [2:0] NOUT = (VARIANT == 0) ? 3'h2 : (VARIANT == 1) ? 3'h4 : 3'h3;

    // ======
    // pin resolution
    logic [1:0]               raw [7];
    xbar_pkg::xbar_level_type lvl [7];

    assign raw[0] = route_pin_0;
    assign raw[1] = route_pin_1;
    assign raw[2] = route_pin_2;
    assign raw[3] = route_pin_3;
    assign raw[4] = route_pin_4;
    assign raw[5] = route_pin_5;
    assign raw[6] = powerdown_n_pin;

    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++)
        begin : g_pin
            xbar_tri_sync u_sync
            (
                .clk     (clk),
                .nrst    (nrst),
                .pin_raw (raw[gi]),
                .level   (lvl[gi])
            );
        end
    endgenerate

    xbar_pkg::xbar_level_type pd_lvl;
    assign pd_lvl = lvl[6];

    logic [1:0] fs_reg;
    logic [1:0] fs_next;

    always_comb
    begin
        fs_next = {fs_reg[0], iface_select};
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            fs_reg <= 2'h0;
        else
            fs_reg <= fs_next;
    end

    // ======
    // decode helpers
    function automatic logic [2:0] lvl_src(input xbar_pkg::xbar_level_type l);
        case (l)
            xbar_pkg::XBAR_LVL_LOW:  lvl_src = `XBAR_SEL_IN0;
            xbar_pkg::XBAR_LVL_MID:  lvl_src = `XBAR_SEL_IN1;
            xbar_pkg::XBAR_LVL_HIGH: lvl_src = `XBAR_SEL_IN2;
            default:                 lvl_src = `XBAR_SEL_OFF;
        endcase
    endfunction : lvl_src

    // four-in/three-out output
    function automatic logic [2:0] pair_src(input xbar_pkg::xbar_level_type up,
                                            input xbar_pkg::xbar_level_type lo);
        pair_src = `XBAR_SEL_OFF;
        if (up == xbar_pkg::XBAR_LVL_LOW)
            pair_src = lvl_src(lo);
        else if (up == xbar_pkg::XBAR_LVL_HIGH && lo == xbar_pkg::XBAR_LVL_LOW)
            pair_src = `XBAR_SEL_IN3;
    endfunction : pair_src

    // three-in/four-out pair
    function automatic logic [5:0] duo_src(input xbar_pkg::xbar_level_type mode,
                                           input xbar_pkg::xbar_level_type sa,
                                           input xbar_pkg::xbar_level_type sb);
        duo_src = {`XBAR_SEL_OFF, `XBAR_SEL_OFF};
        if (mode == xbar_pkg::XBAR_LVL_LOW)
            duo_src = {lvl_src(sa), lvl_src(sb)};
        else if (mode == xbar_pkg::XBAR_LVL_HIGH)
        begin
            if (sb == xbar_pkg::XBAR_LVL_LOW)
                duo_src = {lvl_src(sa), `XBAR_SEL_OFF};
            else if (sb == xbar_pkg::XBAR_LVL_MID)
                duo_src = {`XBAR_SEL_OFF, lvl_src(sa)};
        end
    endfunction : duo_src

    // ======
    // pin decoding
    logic [2:0] pin_sel [4];
    logic       all_mid;
    logic [5:0] duo_hi;
    logic [5:0] duo_lo;

    assign duo_hi = duo_src(lvl[5], lvl[0], lvl[1]);
    assign duo_lo = duo_src(lvl[4], lvl[2], lvl[3]);

    always_comb
    begin
        all_mid = 1'b1;
        for (int i = 0; i < 6; i++)
            if (lvl[i] != xbar_pkg::XBAR_LVL_MID)
                all_mid = 1'b0;
        for (int i = 0; i < 4; i++)
            pin_sel[i] = `XBAR_SEL_OFF;
        if (VARIANT == 1)
        begin
            pin_sel[0] = duo_hi[5:3];
            pin_sel[1] = duo_hi[2:0];
            pin_sel[2] = duo_lo[5:3];
            pin_sel[3] = duo_lo[2:0];
        end
        else if (VARIANT == 2)
        begin
            pin_sel[0] = pair_src(lvl[5], lvl[0]);
            pin_sel[1] = pair_src(lvl[4], lvl[1]);
            pin_sel[2] = pair_src(lvl[3], lvl[2]);
        end
    end

    // ======
    // mode and pin sampling
    xbar_pkg::xbar_mode_type mode_reg;
    xbar_pkg::xbar_mode_type mode_next;
    logic [1:0]              settle_reg;
    logic [1:0]              settle_next;
    logic                    pd_low_reg;
    logic                    pd_low_next;
    logic [11:0]             latch_reg;
    logic [11:0]             latch_next;
    logic                    sample;

    always_comb
    begin
        settle_next = settle_reg;
        if (settle_reg != `XBAR_SETTLE_CYC)
            settle_next = settle_reg + 2'h1;
        pd_low_next = (pd_lvl == xbar_pkg::XBAR_LVL_LOW);
        // sample after reset or power-down exit
        sample = (settle_reg == `XBAR_SETTLE_CYC - 2'h1) ||
                 (pd_low_reg && !pd_low_next);
        mode_next = mode_reg;
        if (settle_reg == `XBAR_SETTLE_CYC - 2'h1)
        begin
            if (VARIANT == 0)
                mode_next = fs_reg[1] ? xbar_pkg::XBAR_MODE_SERIAL
                                      : xbar_pkg::XBAR_MODE_LIN;
            else
                mode_next = all_mid ? xbar_pkg::XBAR_MODE_LIN
                                    : xbar_pkg::XBAR_MODE_SERIAL;
        end
        latch_next = latch_reg;
        if (sample)
            latch_next = {pin_sel[3], pin_sel[2], pin_sel[1], pin_sel[0]};
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            settle_reg <= 2'h0;
            pd_low_reg <= 1'b0;
            mode_reg   <= xbar_pkg::XBAR_MODE_NONE;
            latch_reg  <= '0;
        end
        else
        begin
            settle_reg <= settle_next;
            pd_low_reg <= pd_low_next;
            mode_reg   <= mode_next;
            latch_reg  <= latch_next;
        end
    end

    logic is_lin;
    logic is_ser;
    assign is_lin = (mode_reg == xbar_pkg::XBAR_MODE_LIN);
    assign is_ser = (mode_reg == xbar_pkg::XBAR_MODE_SERIAL);

    // ======
    // routing registers
    logic [7:0] ra_reg;
    logic [7:0] ra_next;
    logic [7:0] rb_reg;
    logic [7:0] rb_next;
    logic       ovr_reg;
    logic       ovr_next;

    always_comb
    begin
        ra_next  = ra_reg;
        rb_next  = rb_reg;
        ovr_next = ovr_reg;
        if (is_ser && ser_wr_valid)
        begin
            if (ser_wr_addr == `XBAR_REG_ROUTE_A)
                ra_next = ser_wr_data;
            if (ser_wr_addr == `XBAR_REG_ROUTE_B)
                rb_next = ser_wr_data;
            if (ser_wr_addr == `XBAR_REG_KEY && ser_wr_data == `XBAR_KEY_VALUE)
                ovr_next = 1'b1;
        end
        if (is_lin && lin_frame_valid && lin_cksum_ok)
        begin
            ra_next = lin_frame_d1;
            rb_next = lin_frame_d2;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ra_reg  <= `XBAR_ROUTE_RST;
            rb_reg  <= `XBAR_ROUTE_RST;
            ovr_reg <= 1'b0;
        end
        else
        begin
            ra_reg  <= ra_next;
            rb_reg  <= rb_next;
            ovr_reg <= ovr_next;
        end
    end

    // ======
    // output selection
    logic [2:0] sel_reg  [4];
    logic [2:0] sel_next [4];
    logic [2:0] reg_sel  [4];
    logic [3:0] reg_pre;
    logic [3:0] pre_reg;
    logic [3:0] pre_next;
    logic       use_regs;

    assign reg_sel[0] = ra_reg[`XBAR_SEL_LO_MSB:0];
    assign reg_sel[1] = ra_reg[`XBAR_SEL_HI_MSB:`XBAR_SEL_HI_LSB];
    assign reg_sel[2] = rb_reg[`XBAR_SEL_LO_MSB:0];
    assign reg_sel[3] = rb_reg[`XBAR_SEL_HI_MSB:`XBAR_SEL_HI_LSB];
    assign reg_pre    = {rb_reg[`XBAR_PRE_HI_BIT], rb_reg[`XBAR_PRE_LO_BIT],
                         ra_reg[`XBAR_PRE_HI_BIT], ra_reg[`XBAR_PRE_LO_BIT]};

    // no pins on three-in/two-out
    assign use_regs = (VARIANT == 0) || is_lin || ovr_reg;

    always_comb
    begin
        pre_next = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            sel_next[i] = use_regs ? reg_sel[i] : latch_reg[3*i +: 3];
            if (sel_next[i] > `XBAR_SEL_IN3)
                sel_next[i] = `XBAR_SEL_OFF;
            if (pd_low_reg || mode_reg == xbar_pkg::XBAR_MODE_NONE || 3'(i) >= NOUT)
                sel_next[i] = `XBAR_SEL_OFF;
            if (3'(i) < NOUT)
            begin
                if (pd_lvl == xbar_pkg::XBAR_LVL_MID)
                    pre_next[i] = 1'b1;
                else if (pd_lvl == xbar_pkg::XBAR_LVL_HIGH)
                    pre_next[i] = reg_pre[i];
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < 4; i++)
                sel_reg[i] <= `XBAR_SEL_OFF;
            pre_reg <= 4'h0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
                sel_reg[i] <= sel_next[i];
            pre_reg <= pre_next;
        end
    end

    // ======
    // wake handshake
    logic wake;
    logic tx_en;
    logic tx_reg;
    logic tx_next;

    xbar_wake #(.TIMEOUT_CYC (TIMEOUT_CYC)) u_wake
    (
        .clk         (clk),
        .nrst        (nrst),
        .enable      (is_lin && !pd_low_reg),
        .sleep_cmd   (lin_sleep_cmd),
        .lin_rx_line (lin_rx_line),
        .wake_ctl    (wake),
        .tx_enable   (tx_en)
    );

    always_comb
    begin
        tx_next = tx_en ? lin_tx_data : 1'b1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            tx_reg <= 1'b1;
        else
            tx_reg <= tx_next;
    end

    // ======
    // outputs
    assign out_port_0_sel = sel_reg[0];
    assign out_port_1_sel = sel_reg[1];
    assign out_port_2_sel = sel_reg[2];
    assign out_port_3_sel = sel_reg[3];
    assign out_preemph    = pre_reg;
    assign lin_mode       = is_lin;
    assign serial_active  = is_ser;
    assign power_down     = pd_low_reg;
    assign route_override = ovr_reg;
    assign route_a_q      = ra_reg;
    assign route_b_q      = rb_reg;
    assign xcvr_wake_ctl  = wake;
    assign lin_tx_line    = tx_reg;
    assign lin_tx_oe      = tx_en;

endmodule : xbar_ctrl

// *** hdl/xbar_consts.svh ***
// Overview of operation
// - 3x4, route_pin_5 low: out 0,1 both on
// - 3x4, route_pin_5 high: route_pin_1 picks one
// - 3x4, route_pin_4 low: out 2,3 both on
// - 3x4, route_pin_4 high: route_pin_3 picks one
// - 4x3, out_port_0 by route_pin_5, route_pin_0
// - 4x3, out_port_1 by route_pin_4, route_pin_1
// - 4x3, out_port_2 by route_pin_3, route_pin_2
// - 3x4 and 4x3, all route pins midlevel selects lin control
// - serial active outside lin; writes override pins only after key
// - 3x2, iface_select low lin, high serial
// - 3x2, outputs start disconnected in both modes
// - xcvr_wake_ctl low after power-up
// - lin_rx_line falling edge raises xcvr_wake_ctl
// - lin_tx_line enabled only after wake raised
// - idle timeout or sleep command lowers wake
// - powerdown pin midlevel forces preemphasis on
// - powerdown pin high: preemphasis from registers
// - powerdown low keeps registers and control mode
// - key 0xff at 0xff hands routing to registers
// - pin changes applied only after reset or powerdown release
// - lin write applied only after checksum good
`ifndef XBAR_CONSTS_SVH
`define XBAR_CONSTS_SVH

// ======
// register map
`define XBAR_REG_ROUTE_A     8'h01
`define XBAR_REG_ROUTE_B     8'h02
`define XBAR_REG_KEY         8'hff
`define XBAR_KEY_VALUE       8'hff
`define XBAR_ROUTE_RST       8'h00

// ======
// field positions
`define XBAR_SEL_LO_MSB      2
`define XBAR_PRE_LO_BIT      3
`define XBAR_SEL_HI_MSB      6
`define XBAR_SEL_HI_LSB      4
`define XBAR_PRE_HI_BIT      7

// ======
// select codes
`define XBAR_SEL_OFF         3'h0
`define XBAR_SEL_IN1         3'h1
`define XBAR_SEL_IN0         3'h2
`define XBAR_SEL_IN2         3'h3
`define XBAR_SEL_IN3         3'h4

// ======
// timing
`define XBAR_CLK_MHZ         10
`define XBAR_IDLE_TIMEOUT_US 4000
`define XBAR_IDLE_TIMEOUT_CYC (`XBAR_IDLE_TIMEOUT_US * `XBAR_CLK_MHZ)
`define XBAR_SETTLE_CYC      2'h3

`endif

// *** hdl/xbar_pkg.sv ***
package xbar_pkg;

    // ======
    // three-level pin code
    typedef enum logic [1:0] {
        XBAR_LVL_LOW  = 2'h0,
        XBAR_LVL_MID  = 2'h1,
        XBAR_LVL_HIGH = 2'h3,
        XBAR_LVL_BAD  = 2'h2
    } xbar_level_type;

    // ======
    // wake states
    typedef enum logic [1:0] {
        XBAR_WK_SLEEP = 2'h0,
        XBAR_WK_AWAKE = 2'h1
    } xbar_wake_type;

    // ======
    // control mode
    typedef enum logic [1:0] {
        XBAR_MODE_NONE   = 2'h0,
        XBAR_MODE_SERIAL = 2'h1,
        XBAR_MODE_LIN    = 2'h3
    } xbar_mode_type;

endpackage : xbar_pkg

// *** hdl/xbar_tri_sync.sv ***
`timescale 1ns/1ps

module xbar_tri_sync
(
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    nrst,
    // comparator pair
    input  wire logic [1:0]              pin_raw,
    // resolved level
    output xbar_pkg::xbar_level_type     level
);

    logic [1:0] meta_reg;
    logic [1:0] meta_next;
    logic [1:0] sync_reg;
    logic [1:0] sync_next;

    // ======
    // two-stage synchroniser
    always_comb
    begin
        meta_next = pin_raw;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_reg <= 2'h1;
            sync_reg <= 2'h1;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    // ======
    // level resolution
    assign level = xbar_pkg::xbar_level_type'(sync_reg);

endmodule : xbar_tri_sync

// *** hdl/xbar_wake.sv ***
`timescale 1ns/1ps
`include "xbar_consts.svh"

module xbar_wake
#(
    parameter int TIMEOUT_CYC = `XBAR_IDLE_TIMEOUT_CYC
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // control
    input  wire logic enable,
    input  wire logic sleep_cmd,
    // transceiver pins
    input  wire logic lin_rx_line,
    output logic      wake_ctl,
    output logic      tx_enable
);

    localparam int CW = $clog2(TIMEOUT_CYC + 1);

    generate
        if (TIMEOUT_CYC < 1)
        begin : g_bad
            $error("xbar_wake: TIMEOUT_CYC must be at least 1");
        end
    endgenerate

    xbar_pkg::xbar_wake_type state_reg;
    xbar_pkg::xbar_wake_type state_next;
    logic [2:0]              rx_reg;
    logic [2:0]              rx_next;
    logic [CW-1:0]           idle_reg;
    logic [CW-1:0]           idle_next;
    logic                    fall;
    logic                    edge_seen;

    // ======
    // rx edge detect
    assign fall      = rx_reg[2] & ~rx_reg[1];
    assign edge_seen = rx_reg[2] ^ rx_reg[1];

    always_comb
    begin
        rx_next   = {rx_reg[1:0], lin_rx_line};
        state_next = state_reg;
        idle_next  = idle_reg;
        case (state_reg)
            xbar_pkg::XBAR_WK_SLEEP:
            begin
                idle_next = '0;
                if (enable && fall)
                    state_next = xbar_pkg::XBAR_WK_AWAKE;
            end
            xbar_pkg::XBAR_WK_AWAKE:
            begin
                if (edge_seen)
                    idle_next = '0;
                else
                    idle_next = idle_reg + 1'b1;
                if (!enable || sleep_cmd || idle_reg == CW'(TIMEOUT_CYC - 1))
                    state_next = xbar_pkg::XBAR_WK_SLEEP;
            end
            default:
                state_next = xbar_pkg::XBAR_WK_SLEEP;
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_reg    <= 3'h7;
            state_reg <= xbar_pkg::XBAR_WK_SLEEP;
            idle_reg  <= '0;
        end
        else
        begin
            rx_reg    <= rx_next;
            state_reg <= state_next;
            idle_reg  <= idle_next;
        end
    end

    assign wake_ctl  = (state_reg == xbar_pkg::XBAR_WK_AWAKE);
    assign tx_enable = wake_ctl;

endmodule : xbar_wake

// *** verif/xbar_ctrl_properties.sv ***
`timescale 1ns/1ps

module xbar_ctrl_chk
#(
    parameter int VARIANT     = 1,
    parameter int TIMEOUT_CYC = 20
)
(
    // clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // pins and engines
    input wire logic [1:0] powerdown_n_pin,
    input wire logic       lin_rx_line,
    input wire logic       ser_wr_valid,
    input wire logic [7:0] ser_wr_addr,
    input wire logic [7:0] ser_wr_data,
    input wire logic       lin_frame_valid,
    input wire logic       lin_cksum_ok,
    input wire logic       lin_sleep_cmd,
    // outputs
    input wire logic [2:0] out_port_0_sel,
    input wire logic [2:0] out_port_1_sel,
    input wire logic [2:0] out_port_2_sel,
    input wire logic [2:0] out_port_3_sel,
    input wire logic [3:0] out_preemph,
    input wire logic       lin_mode,
    input wire logic       serial_active,
    input wire logic       power_down,
    input wire logic       route_override,
    input wire logic [7:0] route_a_q,
    input wire logic [7:0] route_b_q,
    input wire logic       xcvr_wake_ctl,
    input wire logic       lin_tx_line,
    input wire logic       lin_tx_oe
);
    localparam logic [3:0] PRE_ALL = (VARIANT == 0) ? 4'h3 : ((VARIANT == 1) ? 4'hf : 4'h7);
    int idle_cnt;

    // ======
    // quiet cycles awake
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            idle_cnt <= 0;
        else if (xcvr_wake_ctl && $stable(lin_rx_line))
            idle_cnt <= idle_cnt + 1;
        else
            idle_cnt <= 0;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ======
    // properties
    chk_pd_all_off:
    assert property (power_down && $past(power_down) |->
        {out_port_3_sel, out_port_2_sel, out_port_1_sel, out_port_0_sel} == 12'h0)
        else $error("driven in power-down");
    chk_tx_needs_wake:
    assert property (lin_tx_oe |-> xcvr_wake_ctl) else $error("tx enabled asleep");
    chk_tx_idle_high:
    assert property (!xcvr_wake_ctl |-> lin_tx_line) else $error("tx line low asleep");
    chk_wake_in_lin:
    assert property ($rose(xcvr_wake_ctl) |-> lin_mode && !power_down)
        else $error("wake outside lin");
    chk_wake_on_edge:
    assert property (lin_mode && !power_down && !xcvr_wake_ctl && $fell(lin_rx_line)
        |-> ##[1:6] xcvr_wake_ctl) else $error("no wake after rx edge");
    chk_sleep_cmd_drop:
    assert property (lin_sleep_cmd |=> !xcvr_wake_ctl) else $error("awake after sleep cmd");
    chk_idle_bound:
    assert property (idle_cnt <= TIMEOUT_CYC + 6) else $error("idle timeout missed");
    chk_idle_early:
    assert property ($fell(xcvr_wake_ctl) |-> $past(lin_sleep_cmd) || $past(power_down)
        || power_down || !lin_mode || $past(idle_cnt) >= TIMEOUT_CYC)
        else $error("early sleep");
    chk_pre_forced:
    assert property ((powerdown_n_pin == 2'h1) [*5] |-> out_preemph == PRE_ALL)
        else $error("preemphasis not forced");
    chk_reg_a_write:
    assert property (ser_wr_valid && serial_active && ser_wr_addr == 8'h01
        |=> route_a_q == $past(ser_wr_data)) else $error("write lost");
    chk_bad_cksum:
    assert property (lin_frame_valid && !lin_cksum_ok && !ser_wr_valid
        |=> $stable(route_a_q) && $stable(route_b_q)) else $error("bad frame applied");
    chk_key_cause:
    assert property ($rose(route_override) |-> $past(ser_wr_valid)
        && $past(ser_wr_addr) == 8'hff && $past(ser_wr_data) == 8'hff)
        else $error("override without key");
endmodule : xbar_ctrl_chk

// *** verif/xbar_lin_xcvr.sv ***
`timescale 1ns/1ps

module xbar_lin_xcvr
(
    // clock
    input  wire logic clk,
    // device side
    input  wire logic wake_ctl,
    input  wire logic tx_line,
    input  wire logic tx_oe,
    // bus wake event
    input  wire logic bus_wake,
    output logic      rx_line = 1'b1
);
    // ======
    // echo awake, else wake pulse
    always @(posedge clk)
    begin
        if (wake_ctl && tx_oe)
            rx_line <= tx_line;
        else
            rx_line <= !bus_wake;
    end
endmodule : xbar_lin_xcvr

// *** verif/tb_xbar_ctrl.sv ***
`timescale 1ns/1ps

module tb_xbar_ctrl;
    // ======
    // signals
    typedef struct {int due; int kind; logic [11:0] val;} xbar_note_type;
    localparam logic [1:0] LV [3] = '{2'h0, 2'h1, 2'h3};
    localparam logic [2:0] CD [3] = '{3'h2, 3'h1, 3'h3};
    logic       clk = 1'b0;
    logic       nrst;
    logic [1:0] route_pin_0, route_pin_1, route_pin_2, route_pin_3, route_pin_4, route_pin_5;
    logic [1:0] powerdown_n_pin;
    logic       iface_select, lin_rx_line, ser_wr_valid, lin_frame_valid, lin_cksum_ok;
    logic       lin_sleep_cmd, lin_tx_data, bus_wake;
    logic [7:0] ser_wr_addr, ser_wr_data, lin_frame_d1, lin_frame_d2, route_a_q, route_b_q;
    logic [2:0] out_port_0_sel, out_port_1_sel, out_port_2_sel, out_port_3_sel, e0, e2;
    logic [3:0] out_preemph;
    logic       lin_mode, serial_active, power_down, route_override;
    logic       xcvr_wake_ctl, lin_tx_line, lin_tx_oe;
    logic [11:0] sel_vec, prev;
    logic [31:0] seed = 32'h6ce3, r;
    int          pl [4];
    int          k, cyc = 0, err_count = 0, tests_run = 0;
    xbar_note_type q [$];
    xbar_note_type n;

    assign sel_vec = {out_port_3_sel, out_port_2_sel, out_port_1_sel, out_port_0_sel};
    xbar_ctrl #(.VARIANT(1), .TIMEOUT_CYC(20)) dut (.*);
    xbar_lin_xcvr xcvr (.clk(clk), .wake_ctl(xcvr_wake_ctl), .tx_line(lin_tx_line),
        .tx_oe(lin_tx_oe), .bus_wake(bus_wake), .rx_line(lin_rx_line));

    initial
    begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    // ======
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [2:0] sf(input logic [2:0] x);
        return (x > 3'h4) ? 3'h0 : x;
    endfunction : sf
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : tick
    task automatic note(input int dt, input int kd, input logic [11:0] v);
        q.push_back('{cyc + dt, kd, v});
    endtask : note
    task automatic check(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1)
        begin
            err_count++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : check
    task automatic cmp_sel(input logic [11:0] v);
        check(sel_vec === v, "routing");
    endtask : cmp_sel
    task automatic cmp_pre(input logic [3:0] v);
        check(out_preemph === v, "preemphasis");
    endtask : cmp_pre
    task automatic cmp_st(input logic [2:0] v);
        check({lin_mode, xcvr_wake_ctl, lin_tx_oe} === v, "mode or wake");
    endtask : cmp_st
    task automatic pins(input int a5, a4, a3, a2, a1, a0);
        {route_pin_5, route_pin_4, route_pin_3} = {LV[a5], LV[a4], LV[a3]};
        {route_pin_2, route_pin_1, route_pin_0} = {LV[a2], LV[a1], LV[a0]};
    endtask : pins
    task automatic do_reset();
        nrst = 1'b0;
        tick(3);
        nrst = 1'b1;
    endtask : do_reset
    task automatic ser_wr(input logic [7:0] a, input logic [7:0] d);
        {ser_wr_addr, ser_wr_data, ser_wr_valid} = {a, d, 1'b1};
        tick(1);
        ser_wr_valid = 1'b0;
    endtask : ser_wr
    task automatic lin_wr(input logic ok);
        {lin_cksum_ok, lin_frame_valid} = {ok, 1'b1};
        tick(1);
        lin_frame_valid = 1'b0;
    endtask : lin_wr
    task automatic wake_bus();
        bus_wake = 1'b1;
        tick(3);
        bus_wake = 1'b0;
    endtask : wake_bus
    task automatic give_verdict();
        $display("runs %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    // ======
    // result monitor
    always @(negedge clk)
    begin
        while (q.size() > 0 && q[0].due <= cyc)
        begin
            n = q.pop_front();
            if (n.kind == 0)
                cmp_sel(n.val);
            else if (n.kind == 1)
                cmp_pre(n.val[3:0]);
            else
                cmp_st(n.val[2:0]);
        end
    end

    initial
    begin
        repeat (3000) @(posedge clk);
        err_count++;
        give_verdict();
    end

    // ======
    // main sequence
    initial
    begin
        {iface_select, lin_tx_data, ser_wr_valid, lin_frame_valid} = 4'hc;
        {lin_cksum_ok, lin_sleep_cmd, bus_wake, powerdown_n_pin} = 5'h3;
        {ser_wr_addr, ser_wr_data, lin_frame_d1, lin_frame_d2} = 32'h0;
        foreach (pl[i]) pl[i] = rnd() % 3;
        pins(0, 0, pl[3], pl[2], pl[1], pl[0]);
        do_reset();
        prev = {CD[pl[3]], CD[pl[2]], CD[pl[1]], CD[pl[0]]};
        note(8, 0, prev);
        note(8, 2, 12'h0);
        tick(9);
        r = rnd();
        ser_wr(8'h01, r[7:0]);
        note(3, 0, prev);
        tick(4);
        ser_wr(8'hff, 8'hff);
        route_pin_5 = 2'h3;
        note(4, 0, {6'h0, sf(r[6:4]), sf(r[2:0])});
        note(4, 1, {10'h0, r[7], r[3]});
        tick(5);
        for (k = 0; k < 3; k++)
        begin
            pl[0] = rnd() % 3;
            pl[2] = rnd() % 3;
            pins(2, 2, k, pl[2], k, pl[0]);
            if (k == 0)
                do_reset();
            else
            begin
                note(6, 0, prev);
                tick(7);
                powerdown_n_pin = 2'h0;
                note(6, 0, 12'h0);
                tick(7);
                powerdown_n_pin = 2'h3;
            end
            {e0, e2} = {CD[pl[0]], CD[pl[2]]};
            prev = {(k == 1) ? e2 : 3'h0, (k == 0) ? e2 : 3'h0, (k == 1) ? e0 : 3'h0,
                (k == 0) ? e0 : 3'h0};
            note(8, 0, prev);
            note(8, 2, 12'h0);
            tick(9);
        end
        pins(1, 1, 1, 1, 1, 1);
        powerdown_n_pin = 2'h1;
        do_reset();
        note(8, 2, 12'h4);
        note(8, 1, 12'hf);
        tick(9);
        ser_wr(8'h01, 8'h12);
        powerdown_n_pin = 2'h3;
        note(5, 0, 12'h0);
        note(5, 1, 12'h0);
        tick(6);
        wake_bus();
        note(8, 2, 12'h7);
        tick(9);
        note(30, 2, 12'h4);
        tick(31);
        wake_bus();
        tick(8);
        lin_sleep_cmd = 1'b1;
        tick(1);
        lin_sleep_cmd = 1'b0;
        note(2, 2, 12'h4);
        tick(3);
        r = rnd();
        {lin_frame_d1, lin_frame_d2} = r[15:0];
        lin_wr(1'b0);
        note(3, 0, 12'h0);
        tick(4);
        lin_wr(1'b1);
        prev = {sf(r[6:4]), sf(r[2:0]), sf(r[14:12]), sf(r[10:8])};
        note(3, 0, prev);
        note(3, 1, {8'h0, r[7], r[3], r[15], r[11]});
        tick(4);
        powerdown_n_pin = 2'h0;
        route_pin_5 = 2'h0;
        tick(7);
        powerdown_n_pin = 2'h3;
        note(8, 2, 12'h4);
        note(8, 0, prev);
        tick(10);
        give_verdict();
    end
endmodule : tb_xbar_ctrl

bind xbar_ctrl xbar_ctrl_chk #(.VARIANT(VARIANT), .TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.*);
